/* File: core/sbc_consts.svh */
// Register indices, field layouts, reset values and fixed counts of the block.
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH

// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define SBC_IDX_CTRL 10'h116
`define SBC_IDX_LAT 10'h117
`define SBC_IDX_STAT 10'h11F

// ****************************************
// Field layouts and reset values
// ****************************************
`define SBC_CTRL_WMASK 8'h9F
`define SBC_CTRL_RST 8'h05
`define SBC_LAT_W 5
`define SBC_LAT_RST 5'h04
`define SBC_STAT_W 3

// ****************************************
// Synchroniser width and pin bit positions
// ****************************************
`define SBC_PIN_W 5
`define SBC_PIN_TXCLK 4
`define SBC_PIN_TX_MULTIFRAME_SYNC 3
`define SBC_PIN_TXDATA 2
`define SBC_PIN_RXCLK 1
`define SBC_PIN_RXFS 0

`endif

/* File: core/sbc_pkg.sv */
// Types shared by the slip buffer control logic.
package sbc_pkg;

  // Receive buffer mode field encodings.
  typedef enum logic [1:0] {
    SBC_RX_BYPASS_LO = 2'b00,
    SBC_RX_SLIP = 2'b01,
    SBC_RX_FIFO = 2'b10,
    SBC_RX_BYPASS_HI = 2'b11
  } sbc_rx_mode_e;

  // Control register, packed in its bit order from bit 7 down to bit 0.
  typedef struct packed {
    logic tx_buffer_fifo_select;
    logic [1:0] reserved;
    logic force_signaling_hold;
    logic slip_signaling_hold_enable;
    logic rx_frame_sync_direction;
    sbc_rx_mode_e rx_buffer_mode_select;
  } sbc_ctrl_s;

  // One signaling update: channel slot and its four signaling bits.
  typedef struct packed {
    logic [4:0] chan;
    logic [3:0] bits;
  } sbc_sig_s;

  // Signaling hold state after a receive slip.
  typedef enum logic [1:0] {
    SBC_HOLD_IDLE = 2'b00,
    SBC_HOLD_PART = 2'b01,
    SBC_HOLD_FULL = 2'b10
  } sbc_hold_e;

endpackage

/* File: core/sbc_delay.sv */
// Programmable serial delay line used by the transmit and receive buffers.
`timescale 1ns/100ps
module sbc_delay #(
  parameter int DEPTH = 32,
  parameter int LW = 5
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic shift_en,
  input wire logic din,
  input wire logic [LW-1:0] lat,
  output logic dout
);

  logic [DEPTH-1:0] sr;

  // ****************************************
  // Shift storage and tap
  // ****************************************

  // Shifts one bit per serial clock edge; the tap gives exactly lat periods.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sr <= '0;
      dout <= 1'b0;
    end else if (shift_en) begin
      sr <= {sr[DEPTH-2:0], din};
      if (lat == '0) begin
        dout <= din;
      end else begin
        dout <= sr[lat - 1'b1];
      end
    end
  end

endmodule

/* File: core/sbc_top.sv */
// Slip buffer control: modes, pin directions, signaling hold, APB registers.
//
// Operation
// - Transmit mode bit: 0 slip buffer, 1 FIFO; slip buffer after reset.
// - Transmit serial clock pin is strictly an input to this block.
// - Transmit FIFO latency follows the channel's latency register.
// - Force hold blocks signaling updates to pin and array; clear lets them.
// - Slip hold on: freeze signaling at least one multiframe after a slip.
// - Buffer on: direction bit 0 drives frame sync, 1 receives; resets 1.
// - Mode 00 or 11 bypasses; receive clock and frame sync both outputs.
// - Mode 01 slip, 10 FIFO; receive clock is input; reset value 01.
`timescale 1ns/100ps
`include "sbc_consts.svh"
module sbc_top #(
  parameter int ADDR_W = 12,
  parameter int DEPTH = 32,
  parameter logic [`SBC_LAT_W-1:0] SLIP_LATENCY = 5'h10
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TX_SERIAL_CLOCK,
  input wire logic TX_MULTIFRAME_SYNC,
  input wire logic TX_SER_DATA,
  output logic TX_LINE_DATA,
  output logic TX_LINE_MSYNC,
  output logic TX_LINE_STB,
  input wire logic RX_LINE_DATA,
  input wire logic RX_LINE_STB,
  input wire logic RX_FRAME_STB,
  input wire logic RX_MFRAME_STB,
  input wire logic RX_SLIP_EVENT,
  output logic RX_SER_DATA,
  input wire logic RX_SERIAL_CLOCK_I,
  output logic RX_SERIAL_CLOCK_O,
  output logic RX_SERIAL_CLOCK_OE_N,
  input wire logic RX_FRAME_SYNC_I,
  output logic RX_FRAME_SYNC_O,
  output logic RX_FRAME_SYNC_OE_N,
  input wire logic SIG_UPD_VALID,
  input wire sbc_pkg::sbc_sig_s SIG_UPD,
  output sbc_pkg::sbc_sig_s RX_SIGNALING_OUT,
  output logic RX_SIGNALING_STB,
  output logic RX_SIG_ARRAY_WE,
  output sbc_pkg::sbc_sig_s RX_SIG_ARRAY_WDATA
);

  // ****************************************
  // Declarations
  // ****************************************
  sbc_pkg::sbc_ctrl_s ctrl;
  logic [`SBC_LAT_W-1:0] latency;
  sbc_pkg::sbc_hold_e hold_state;
  sbc_pkg::sbc_hold_e next_hold_state;
  logic [`SBC_PIN_W-1:0] pin_meta;
  logic [`SBC_PIN_W-1:0] pin_sync;
  logic [`SBC_PIN_W-1:0] pin_last;
  logic tx_clk_rise;
  logic rx_clk_rise;
  logic rx_buf_on;
  logic rx_fifo_on;
  logic rx_fs_input;
  logic frozen;
  logic rx_shift_d;
  logic rx_delay_out;
  logic rx_line_bit;
  logic [`SBC_LAT_W-1:0] tx_lat;
  logic [`SBC_LAT_W-1:0] rx_lat;
  logic [9:0] idx;
  logic idx_ok;
  logic setup;
  logic wr_access;
  logic [7:0] rd_byte;
  logic [`SBC_STAT_W-1:0] status;

  // ****************************************
  // APB slave
  // ****************************************

  // Zero wait states; word index from the byte address, bits 1:0 ignored.
  assign PREADY = 1'b1;
  assign idx = PADDR[11:2];
  assign setup = PSEL && !PENABLE;
  assign wr_access = PSEL && PENABLE && PWRITE && !PSLVERR && PSTRB[0];
  assign idx_ok = (idx == `SBC_IDX_CTRL) || (idx == `SBC_IDX_LAT) ||
                  (idx == `SBC_IDX_STAT);

  // Read mux; reserved and unused bits read as zero.
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      `SBC_IDX_CTRL: rd_byte = ctrl;
      `SBC_IDX_LAT: rd_byte = {3'h0, latency};
      `SBC_IDX_STAT: rd_byte = {5'h00, status};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data and error are captured in the setup cycle for the access cycle.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA <= PWRITE ? 32'h00000000 : {24'h000000, rd_byte};
      PSLVERR <= !idx_ok;
    end
  end

  // Control register: reserved bits stay zero.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl <= sbc_pkg::sbc_ctrl_s'(`SBC_CTRL_RST);
    end else if (wr_access && idx == `SBC_IDX_CTRL) begin
      ctrl <= sbc_pkg::sbc_ctrl_s'(PWDATA[7:0] & `SBC_CTRL_WMASK);
    end
  end

  // FIFO latency register, low five bits only.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      latency <= `SBC_LAT_RST;
    end else if (wr_access && idx == `SBC_IDX_LAT) begin
      latency <= PWDATA[`SBC_LAT_W-1:0];
    end
  end

  // Status: hold active, receive clock pin input, frame sync pin input.
  assign status = {rx_fs_input, rx_buf_on, frozen};

  // ****************************************
  // Pin synchronisers
  // ****************************************

  // Two flops for every pin from the backplane; a third copy finds edges.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_last <= '0;
    end else begin
      pin_meta <= {TX_SERIAL_CLOCK, TX_MULTIFRAME_SYNC, TX_SER_DATA,
                   RX_SERIAL_CLOCK_I, RX_FRAME_SYNC_I};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // The transmit clock is only ever sampled, never driven.
  assign tx_clk_rise = pin_sync[`SBC_PIN_TXCLK] &&
                       !pin_last[`SBC_PIN_TXCLK];
  assign rx_clk_rise = pin_sync[`SBC_PIN_RXCLK] && !pin_last[`SBC_PIN_RXCLK];

  // ****************************************
  // Transmit buffer
  // ****************************************

  // FIFO mode uses the programmed latency, slip mode a fixed depth.
  assign tx_lat = ctrl.tx_buffer_fifo_select ? latency : SLIP_LATENCY;

  // Delay line on transmit clock edges; its tap flop is the line data.
  sbc_delay #(
    .DEPTH(DEPTH),
    .LW(`SBC_LAT_W)
  ) u_tx_delay (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .shift_en(tx_clk_rise),
    .din(pin_sync[`SBC_PIN_TXDATA]),
    .lat(tx_lat),
    .dout(TX_LINE_DATA)
  );

  // Multiframe sync is taken on the same edge as data; no slip handling.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_LINE_MSYNC <= 1'b0;
      TX_LINE_STB <= 1'b0;
    end else begin
      TX_LINE_STB <= tx_clk_rise;
      if (tx_clk_rise) begin
        TX_LINE_MSYNC <= pin_sync[`SBC_PIN_TX_MULTIFRAME_SYNC];
      end
    end
  end

  // ****************************************
  // Receive buffer and pin directions
  // ****************************************

  // Modes 01 and 10 enable the buffer; 00 and 11 bypass it.
  assign rx_buf_on =
    (ctrl.rx_buffer_mode_select == sbc_pkg::SBC_RX_SLIP) ||
    (ctrl.rx_buffer_mode_select == sbc_pkg::SBC_RX_FIFO);
  assign rx_fifo_on =
    ctrl.rx_buffer_mode_select == sbc_pkg::SBC_RX_FIFO;
  assign rx_fs_input = rx_buf_on && ctrl.rx_frame_sync_direction;

  // Enables are low while driving: clock driven in bypass only.
  assign RX_SERIAL_CLOCK_OE_N = rx_buf_on;
  assign RX_FRAME_SYNC_OE_N = rx_fs_input;

  // Receive latency: programmed in FIFO mode, fixed in slip mode.
  assign rx_lat = rx_fifo_on ? latency : SLIP_LATENCY;

  // Last line bit, written into the buffer on backplane clock edges.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_line_bit <= 1'b0;
    end else if (RX_LINE_STB) begin
      rx_line_bit <= RX_LINE_DATA;
    end
  end

  sbc_delay #(
    .DEPTH(DEPTH),
    .LW(`SBC_LAT_W)
  ) u_rx_delay (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .shift_en(rx_clk_rise && rx_buf_on),
    .din(rx_line_bit),
    .lat(rx_lat),
    .dout(rx_delay_out)
  );

  // Marks the cycle after a shift, once the tap flop holds the new bit.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_shift_d <= 1'b0;
    end else begin
      rx_shift_d <= rx_clk_rise && rx_buf_on;
    end
  end

  // Bypass forwards line data with a one-cycle low clock pulse per bit.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      RX_SER_DATA <= 1'b0;
      RX_SERIAL_CLOCK_O <= 1'b1;
      RX_FRAME_SYNC_O <= 1'b0;
    end else begin
      RX_FRAME_SYNC_O <= RX_FRAME_STB;
      if (rx_buf_on) begin
        RX_SERIAL_CLOCK_O <= 1'b1;
        if (rx_shift_d) begin
          RX_SER_DATA <= rx_delay_out;
        end
      end else if (RX_LINE_STB) begin
        RX_SER_DATA <= RX_LINE_DATA;
        RX_SERIAL_CLOCK_O <= 1'b0;
      end else begin
        RX_SERIAL_CLOCK_O <= 1'b1;
      end
    end
  end

  // ****************************************
  // Signaling hold after a receive slip
  // ****************************************

  // A slip waits out the partial multiframe and then one whole one.
  always_comb begin
    next_hold_state = hold_state;
    case (hold_state)
      sbc_pkg::SBC_HOLD_IDLE: begin
        if (RX_SLIP_EVENT && ctrl.slip_signaling_hold_enable) begin
          next_hold_state = sbc_pkg::SBC_HOLD_PART;
        end
      end
      sbc_pkg::SBC_HOLD_PART: begin
        if (RX_MFRAME_STB) begin
          next_hold_state = sbc_pkg::SBC_HOLD_FULL;
        end
      end
      sbc_pkg::SBC_HOLD_FULL: begin
        if (RX_MFRAME_STB) begin
          next_hold_state = sbc_pkg::SBC_HOLD_IDLE;
        end
      end
      default: next_hold_state = sbc_pkg::SBC_HOLD_IDLE;
    endcase
    // A new slip restarts the hold; disabling the feature releases it.
    if (!ctrl.slip_signaling_hold_enable) begin
      next_hold_state = sbc_pkg::SBC_HOLD_IDLE;
    end else if (RX_SLIP_EVENT) begin
      next_hold_state = sbc_pkg::SBC_HOLD_PART;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      hold_state <= sbc_pkg::SBC_HOLD_IDLE;
    end else begin
      hold_state <= next_hold_state;
    end
  end

  // Updates are blocked by the force bit or by a slip hold.
  assign frozen = ctrl.force_signaling_hold ||
                  (hold_state != sbc_pkg::SBC_HOLD_IDLE);

  // Accepted updates go to the pin and the array in the same cycle.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      RX_SIGNALING_OUT <= '0;
      RX_SIGNALING_STB <= 1'b0;
      RX_SIG_ARRAY_WE <= 1'b0;
      RX_SIG_ARRAY_WDATA <= '0;
    end else begin
      RX_SIGNALING_STB <= SIG_UPD_VALID && !frozen;
      RX_SIG_ARRAY_WE <= SIG_UPD_VALID && !frozen;
      if (SIG_UPD_VALID && !frozen) begin
        RX_SIGNALING_OUT <= SIG_UPD;
        RX_SIG_ARRAY_WDATA <= SIG_UPD;
      end
    end
  end

endmodule

/* File: test/sbc_backplane.sv */
// Model of the backplane serial side facing the block.
`timescale 1ns/100ps
module sbc_backplane (
  input wire logic clk,
  input wire logic run,
  input wire logic lstb,
  output logic tclk,
  output logic tmsync,
  output logic tdata,
  output logic rclk,
  output logic rfs
);
  logic [4:0] lf = 5'h01;
  logic [3:0] n = 4'h0;
  logic [2:0] div = 3'h0;
  initial {tclk, tmsync, rclk, rfs} = 4'h0;
  // The tx clock toggles every eight system clocks (80 ns) while running.
  always @(posedge clk) begin
    div <= run ? div + 3'h1 : 3'h0;
    if (!run) tclk <= 1'b0;
    else if (div == 3'h7) tclk <= !tclk;
  end
  // Data and sync move on the falling edge, so they are steady at rising.
  always @(negedge tclk) begin
    lf <= {lf[3:0], lf[4] ^ lf[2]};
    n <= n + 4'h1;
    tmsync <= n == 4'hF;
  end
  assign tdata = lf[0];
  // The rx clock follows the recovered line strobe, so it never drifts.
  always @(posedge clk) if (lstb) rclk <= !rclk;
  always @(negedge rclk) rfs <= !rfs;
endmodule

/* File: test/sbc_top_asserts.sv */
// Checker of the slip buffer control ports.
`timescale 1ns/100ps
`include "sbc_consts.svh"
module sbc_top_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic TX_LINE_STB,
  input wire logic RX_LINE_DATA,
  input wire logic RX_LINE_STB,
  input wire logic RX_SLIP_EVENT,
  input wire logic RX_SER_DATA,
  input wire logic RX_SERIAL_CLOCK_O,
  input wire logic RX_SERIAL_CLOCK_OE_N,
  input wire logic RX_FRAME_STB,
  input wire logic RX_FRAME_SYNC_O,
  input wire logic RX_FRAME_SYNC_OE_N,
  input wire logic SIG_UPD_VALID,
  input wire sbc_pkg::sbc_sig_s SIG_UPD,
  input wire sbc_pkg::sbc_sig_s RX_SIGNALING_OUT,
  input wire logic RX_SIGNALING_STB,
  input wire logic RX_SIG_ARRAY_WE,
  input wire sbc_pkg::sbc_sig_s RX_SIG_ARRAY_WDATA
);
  // ********
  // Shadow of the control register
  // ********
  logic [7:0] ctl;
  logic [1:0] age;
  wire [ADDR_W-3:0] idx = PADDR[ADDR_W-1:2];
  wire hit = idx == `SBC_IDX_CTRL || idx == `SBC_IDX_LAT
    || idx == `SBC_IDX_STAT;
  wire wr = PSEL && PENABLE && PWRITE && PSTRB[0] && idx == `SBC_IDX_CTRL;
  wire ok = age == 2'h3;
  wire bufon = ctl[0] ^ ctl[1];
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // Age counts edges since the last control write, so outputs may settle.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctl <= `SBC_CTRL_RST;
      age <= 2'h0;
    end else if (wr) begin
      ctl <= PWDATA[7:0] & `SBC_CTRL_WMASK;
      age <= 2'h0;
    end else if (!ok) begin
      age <= age + 2'h1;
    end
  end
  AST_UNMAPPED: assert property (PSEL && PENABLE && !hit |->
    PSLVERR && PRDATA == 32'h0) else $error("unmapped access not refused");
  AST_RXCLK_DIR: assert property (ok |->
    RX_SERIAL_CLOCK_OE_N == bufon) else $error("rx clock direction");
  AST_FS_DIR: assert property (ok |->
    RX_FRAME_SYNC_OE_N == (bufon && ctl[2])) else $error("sync direction");
  AST_BYP_CLK: assert property (ok && !bufon && RX_LINE_STB |=>
    !RX_SERIAL_CLOCK_O && RX_SER_DATA == $past(RX_LINE_DATA)
    ##1 RX_SERIAL_CLOCK_O) else $error("bypass clock or data");
  AST_FORCE: assert property (ok && ctl[4] && SIG_UPD_VALID |=>
    !RX_SIGNALING_STB) else $error("update passed while forced");
  AST_PASS: assert property (ok && ctl[4:3] == 2'h0 &&
    SIG_UPD_VALID |=> RX_SIGNALING_STB && RX_SIGNALING_OUT == $past(SIG_UPD))
    else $error("update not passed");
  AST_FS_OUT: assert property (ok |=>
    RX_FRAME_SYNC_O == $past(RX_FRAME_STB)) else $error("frame sync out");
  AST_SLIP: assert property (ok && ctl[3] && RX_SLIP_EVENT
    ##1 SIG_UPD_VALID |=> !RX_SIGNALING_STB) else $error("slip hold");
  AST_ARRAY: assert property (RX_SIG_ARRAY_WE == RX_SIGNALING_STB
    && RX_SIG_ARRAY_WDATA == RX_SIGNALING_OUT) else $error("array write");
  AST_TX_GAP: assert property (TX_LINE_STB |=> !TX_LINE_STB [*3])
    else $error("tx strobes too close");
  cover property (ctl[3] && RX_SLIP_EVENT);
  cover property (ctl[7] && TX_LINE_STB);
  cover property (PSEL && PENABLE && PSLVERR);
endmodule
bind sbc_top sbc_top_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .CLK_SYS, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
  .PRDATA, .PSLVERR, .TX_LINE_STB, .RX_LINE_DATA, .RX_LINE_STB,
  .RX_SLIP_EVENT, .RX_SER_DATA, .RX_SERIAL_CLOCK_O, .RX_SERIAL_CLOCK_OE_N,
  .RX_FRAME_STB, .RX_FRAME_SYNC_O, .RX_FRAME_SYNC_OE_N, .SIG_UPD_VALID,
  .SIG_UPD, .RX_SIGNALING_OUT,
  .RX_SIGNALING_STB, .RX_SIG_ARRAY_WE, .RX_SIG_ARRAY_WDATA);

/* File: test/slip_buffer_control_tb.sv */
// Self-checking bench of the slip buffer control block.
`timescale 1ns/100ps
`include "sbc_consts.svh"
module slip_buffer_control_tb;
  // ********
  // Signals and instances
  // ********
  localparam logic [4:0] SLIP_L = 5'h10;
  localparam logic [11:0] A_CTRL = {`SBC_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_LAT = {`SBC_IDX_LAT, 2'b00};
  localparam logic [11:0] A_STAT = {`SBC_IDX_STAT, 2'b00};
  int mismatches = 0;
  int checks = 0;
  logic CLK_SYS = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, run = 1'b0, SIG_UPD_VALID = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [3:0] PSTRB = 4'hF;
  logic RX_LINE_DATA = 1'b0, RX_LINE_STB = 1'b0, RX_FRAME_STB = 1'b0;
  logic RX_MFRAME_STB = 1'b0, RX_SLIP_EVENT = 1'b0;
  sbc_pkg::sbc_sig_s SIG_UPD = 9'h000, RX_SIGNALING_OUT, RX_SIG_ARRAY_WDATA;
  logic PREADY, PSLVERR, TX_LINE_DATA, TX_LINE_MSYNC, TX_LINE_STB;
  logic RX_SER_DATA, RX_SERIAL_CLOCK_O, RX_SERIAL_CLOCK_OE_N, p_rclk;
  logic RX_FRAME_SYNC_O, RX_FRAME_SYNC_OE_N, RX_SIGNALING_STB, p_rfs;
  logic RX_SIG_ARRAY_WE, TX_SERIAL_CLOCK, TX_MULTIFRAME_SYNC, TX_SER_DATA;
  logic [7:0] cyc = 8'h00;
  logic txq[$];
  logic ms_rise = 1'b0;
  wire logic RX_SERIAL_CLOCK_I = RX_SERIAL_CLOCK_OE_N ? p_rclk
    : RX_SERIAL_CLOCK_O;
  wire logic RX_FRAME_SYNC_I = RX_FRAME_SYNC_OE_N ? p_rfs : RX_FRAME_SYNC_O;
  always #5 CLK_SYS = !CLK_SYS;
  sbc_top #(.SLIP_LATENCY(SLIP_L)) DUT (
    .CLK_SYS, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
    .PRDATA, .PREADY, .PSLVERR, .TX_SERIAL_CLOCK, .TX_MULTIFRAME_SYNC,
    .TX_SER_DATA, .TX_LINE_DATA, .TX_LINE_MSYNC, .TX_LINE_STB,
    .RX_LINE_DATA, .RX_LINE_STB, .RX_FRAME_STB, .RX_MFRAME_STB,
    .RX_SLIP_EVENT, .RX_SER_DATA, .RX_SERIAL_CLOCK_I, .RX_SERIAL_CLOCK_O,
    .RX_SERIAL_CLOCK_OE_N, .RX_FRAME_SYNC_I, .RX_FRAME_SYNC_O,
    .RX_FRAME_SYNC_OE_N, .SIG_UPD_VALID, .SIG_UPD, .RX_SIGNALING_OUT,
    .RX_SIGNALING_STB, .RX_SIG_ARRAY_WE, .RX_SIG_ARRAY_WDATA);
  sbc_backplane u_bp (.clk(CLK_SYS), .run, .lstb(RX_LINE_STB),
    .tclk(TX_SERIAL_CLOCK), .tmsync(TX_MULTIFRAME_SYNC),
    .tdata(TX_SER_DATA), .rclk(p_rclk), .rfs(p_rfs));
  // Line side: a bit strobe every 4 cycles, a frame pulse every 32.
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 8'h01;
    RX_LINE_STB <= cyc[1:0] == 2'h0;
    RX_LINE_DATA <= cyc[3] ^ cyc[6];
    RX_FRAME_STB <= cyc[4:0] == 5'h00;
  end
  // Bits sent by the far side, one per tx clock edge.
  always @(posedge TX_SERIAL_CLOCK) begin
    txq.push_back(TX_SER_DATA);
    ms_rise = TX_MULTIFRAME_SYNC;
  end
  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS) PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic sig(input logic [8:0] v, input logic pass);
    SIG_UPD <= v;
    SIG_UPD_VALID <= 1'b1;
    @(posedge CLK_SYS) SIG_UPD_VALID <= 1'b0;
    @(posedge CLK_SYS);
    chk(RX_SIGNALING_STB, pass);
    if (pass) chk(RX_SIGNALING_OUT, v);
  endtask
  task automatic tx_run(input int l);
    repeat (3) @(posedge CLK_SYS iff TX_LINE_STB === 1'b1);
    repeat (40) begin
      @(posedge CLK_SYS iff TX_LINE_STB === 1'b1);
      if (txq.size() > l + 1) chk(TX_LINE_DATA, txq[$ - l]);
      chk(TX_LINE_MSYNC, ms_rise);
    end
  endtask
  task automatic reg_test();
    logic [31:0] r;
    logic e;
    apb(1'b0, A_CTRL, 32'h0, r, e);
    chk(r, 32'h05);
    PSTRB <= 4'h0;
    apb(1'b1, A_LAT, 32'h1F, r, e);
    PSTRB <= 4'hF;
    apb(1'b0, A_LAT, 32'h0, r, e);
    chk(r, 32'h04);
    apb(1'b1, A_CTRL, 32'hFF, r, e);
    apb(1'b0, A_CTRL, 32'h0, r, e);
    chk(r, 32'h9F);
    apb(1'b1, 12'h460, 32'hFF, r, e);
    chk(e, 1'b1);
    apb(1'b0, 12'h460, 32'h0, r, e);
    chk(r, 32'h0);
  endtask
  task automatic dir_test();
    logic [31:0] r;
    logic e;
    logic [2:0] v;
    logic b;
    for (int m = 0; m < 8; m++) begin
      v = 3'(m);
      b = v[1] ^ v[0];
      apb(1'b1, A_CTRL, {29'h0, v}, r, e);
      repeat (8) @(posedge CLK_SYS);
      chk(RX_SERIAL_CLOCK_OE_N, b);
      chk(RX_FRAME_SYNC_OE_N, b & v[2]);
      apb(1'b0, A_STAT, 32'h0, r, e);
      chk(r, {29'h0, b & v[2], b, 1'b0});
    end
  endtask
  task automatic sig_test();
    logic [31:0] r;
    logic e;
    apb(1'b1, A_CTRL, 32'h15, r, e);
    repeat (2) @(posedge CLK_SYS);
    sig(9'h1A5, 1'b0);
    apb(1'b1, A_CTRL, 32'h05, r, e);
    repeat (2) @(posedge CLK_SYS);
    sig(9'h05A, 1'b1);
    apb(1'b1, A_CTRL, 32'h0D, r, e);
    repeat (2) @(posedge CLK_SYS);
    RX_SLIP_EVENT <= 1'b1;
    @(posedge CLK_SYS) RX_SLIP_EVENT <= 1'b0;
    sig(9'h033, 1'b0);
    apb(1'b0, A_STAT, 32'h0, r, e);
    chk(r, 32'h7);
    for (int i = 0; i < 2; i++) begin
      RX_MFRAME_STB <= 1'b1;
      @(posedge CLK_SYS) RX_MFRAME_STB <= 1'b0;
      @(posedge CLK_SYS);
      sig(9'h0C3, i[0]);
    end
  endtask
  task automatic tx_test();
    logic [31:0] r;
    logic e;
    apb(1'b1, A_CTRL, 32'h05, r, e);
    tx_run(SLIP_L);
    apb(1'b1, A_CTRL, 32'h85, r, e);
    tx_run(4);
    apb(1'b1, A_LAT, 32'h00, r, e);
    tx_run(0);
    apb(1'b1, A_LAT, 32'h1F, r, e);
    tx_run(31);
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ********
  // Main sequence and watchdog
  // ********
  initial begin
    repeat (12) @(posedge CLK_SYS);
    ARST_N <= 1'b1;
    run <= 1'b1;
    @(posedge CLK_SYS);
    reg_test();
    dir_test();
    sig_test();
    tx_test();
    report_and_stop();
  end
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule
